/* rtl/mesc_pkg.sv */
package mesc_pkg;

	// ****************************************
	// Register map (byte addresses).
	// ****************************************
	localparam logic [7:0] ADDR_SHORT = 8'h00;
	localparam logic [7:0] ADDR_HBEAT = 8'h04;
	localparam logic [7:0] ADDR_LMIS = 8'h08;
	localparam logic [7:0] ADDR_CFG = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;

	// ****************************************
	// Fields and reset values.
	// ****************************************
	localparam int CNT_W = 8;
	localparam int CFG_LEN_CHECK_BIT = 16;
	localparam int CFG_HALF_DUPLEX_BIT = 1;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam int EV_SHORT = 0;
	localparam int EV_HBEAT = 1;
	localparam int EV_LMIS = 2;
	localparam int EV_W = 3;

	// ****************************************
	// Frame limits and timing.
	// ****************************************
	localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
	localparam logic [15:0] TYPE_ID_MIN = 16'h0600;
	localparam int HB_WINDOW_BITS = 96;
	localparam int BIT_TIME_PS = 10000;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int HB_WINDOW_CYC = (HB_WINDOW_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		HB_IDLE,
		HB_TX,
		HB_WAIT
	} mesc_hb_state_t;

endpackage : mesc_pkg

/* rtl/mesc_cnt_if.sv */
`timescale 1ns/1ps
interface mesc_cnt_if;
	logic inc;
	logic wr;
	logic [7:0] wdata;
	logic [7:0] value;
	modport owner (input inc, input wr, input wdata, output value);
	modport user (output inc, output wr, output wdata, input value);
endinterface : mesc_cnt_if

/* rtl/mesc_counter.sv */
`timescale 1ns/1ps
module mesc_counter (
	input wire logic hclk,
	input wire logic hresetn,
	mesc_cnt_if.owner cnt
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt.wr) begin
			cnt_nxt = cnt.wdata;
		end else if (cnt.inc) begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= mesc_pkg::CNT_RESET;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt.value = cnt_r;
endmodule : mesc_counter

/* rtl/mesc_stats.sv */
// Contract
// R1 - Count each received frame under 64 bytes that has no CRC, alignment or symbol error.
// R2 - In half duplex, count a failed heartbeat when no collision shows within 96 bit times.
// R3 - Count each received frame whose measured length is below its length field value.
// R4 - Length mismatch checking runs only while configuration bit 16 is set.
// R5 - Frames with length/type of 0x0600 or more, or of excessive length, are not mismatches.
// R6 - Each counter is read and written by software as 8 bits, upper bits reading zero.
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module mesc_stats #(
	parameter int HB_CYC = mesc_pkg::HB_WINDOW_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rx_frame_done,
	input wire logic [15:0] rx_frame_len,
	input wire logic [15:0] rx_len_field,
	input wire logic rx_crc_err,
	input wire logic rx_align_err,
	input wire logic rx_symbol_err,
	input wire logic rx_too_long,
	input wire logic tx_en,
	input wire logic collision_indication,
	output logic irq
);
	mesc_cnt_if cnt_if [mesc_pkg::EV_W] ();

	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] cfg_r, cfg_nxt;
	logic [2:0] stat_r, stat_nxt;
	logic [2:0] mask_r, mask_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic [2:0] ev;
	logic [2:0] cnt_wr;
	logic addr_ph;

	// ****************************************
	// Frame event detection.
	// ****************************************
	logic rx_clean;
	logic lmis_ev;
	assign rx_clean = !rx_crc_err && !rx_align_err && !rx_symbol_err;
	assign ev[mesc_pkg::EV_SHORT] = rx_frame_done && rx_clean
		&& (rx_frame_len < mesc_pkg::MIN_FRAME_BYTES); // R1
	assign lmis_ev = rx_frame_done && cfg_r[mesc_pkg::CFG_LEN_CHECK_BIT] // R4
		&& (rx_len_field < mesc_pkg::TYPE_ID_MIN) && !rx_too_long // R5
		&& (rx_frame_len < rx_len_field); // R3
	assign ev[mesc_pkg::EV_LMIS] = lmis_ev;

	// ****************************************
	// Heartbeat test timer.
	// ****************************************
	mesc_pkg::mesc_hb_state_t hb_r, hb_nxt;
	logic [15:0] hb_cnt_r, hb_cnt_nxt;
	logic hb_fail;

	always_comb begin
		hb_nxt = hb_r;
		hb_cnt_nxt = hb_cnt_r;
		hb_fail = 1'b0;
		case (hb_r)
			mesc_pkg::HB_IDLE: begin
				if (tx_en && cfg_r[mesc_pkg::CFG_HALF_DUPLEX_BIT]) begin
					hb_nxt = mesc_pkg::HB_TX;
				end
			end
			mesc_pkg::HB_TX: begin
				if (!tx_en) begin
					hb_nxt = mesc_pkg::HB_WAIT;
					hb_cnt_nxt = 16'h0000;
				end
			end
			mesc_pkg::HB_WAIT: begin
				if (collision_indication) begin
					hb_nxt = mesc_pkg::HB_IDLE;
				end else if (hb_cnt_r == 16'(HB_CYC - 1)) begin
					hb_fail = 1'b1; // R2
					hb_nxt = mesc_pkg::HB_IDLE;
				end else begin
					hb_cnt_nxt = hb_cnt_r + 16'h0001;
				end
			end
			default: hb_nxt = mesc_pkg::HB_IDLE;
		endcase
	end
	assign ev[mesc_pkg::EV_HBEAT] = hb_fail;

	// ****************************************
	// AHB-Lite slave and registers.
	// ****************************************
	assign addr_ph = hsel && hready && htrans[1];

	function automatic logic [2:0] cnt_sel(input logic [7:0] a);
		cnt_sel = {a == mesc_pkg::ADDR_LMIS, a == mesc_pkg::ADDR_HBEAT,
			a == mesc_pkg::ADDR_SHORT};
	endfunction : cnt_sel

	assign cnt_wr = wr_pend_r ? cnt_sel(wr_addr_r) : 3'h0;

	generate
		for (genvar i = 0; i < mesc_pkg::EV_W; i++) begin : g_cnt
			assign cnt_if[i].inc = ev[i]; // R6
			assign cnt_if[i].wr = cnt_wr[i];
			assign cnt_if[i].wdata = hwdata[7:0];
			mesc_counter u_cnt (
				.hclk(hclk),
				.hresetn(hresetn),
				.cnt(cnt_if[i])
			);
		end
	endgenerate

	always_comb begin
		wr_pend_nxt = addr_ph && hwrite;
		wr_addr_nxt = addr_ph ? haddr : wr_addr_r;
		cfg_nxt = cfg_r;
		mask_nxt = mask_r;
		// A new event wins over a write-one clear in the same cycle.
		stat_nxt = stat_r;
		if (wr_pend_r && wr_addr_r == mesc_pkg::ADDR_CFG) begin
			cfg_nxt = hwdata;
		end
		if (wr_pend_r && wr_addr_r == mesc_pkg::ADDR_MASK) begin
			mask_nxt = hwdata[2:0];
		end
		if (wr_pend_r && wr_addr_r == mesc_pkg::ADDR_STAT) begin
			stat_nxt = stat_r & ~hwdata[2:0];
		end
		stat_nxt = stat_nxt | ev;
		rdata_nxt = 32'h0000_0000;
		if (addr_ph && !hwrite) begin
			case (haddr)
				mesc_pkg::ADDR_SHORT: rdata_nxt = {24'h0, cnt_if[0].value}; // R6
				mesc_pkg::ADDR_HBEAT: rdata_nxt = {24'h0, cnt_if[1].value};
				mesc_pkg::ADDR_LMIS: rdata_nxt = {24'h0, cnt_if[2].value};
				mesc_pkg::ADDR_CFG: rdata_nxt = cfg_r;
				mesc_pkg::ADDR_STAT: rdata_nxt = {29'h0, stat_r};
				mesc_pkg::ADDR_MASK: rdata_nxt = {29'h0, mask_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			cfg_r <= mesc_pkg::CFG_RESET;
			stat_r <= 3'h0;
			mask_r <= 3'h0;
			rdata_r <= 32'h0000_0000;
			irq_r <= 1'b0;
			hb_r <= mesc_pkg::HB_IDLE;
			hb_cnt_r <= 16'h0000;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			cfg_r <= cfg_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			hb_r <= hb_nxt;
			hb_cnt_r <= hb_cnt_nxt;
		end
	end

	// The slave never stalls and never errors, but both answers still leave a flip-flop.
	logic ready_r;
	logic resp_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_r <= 1'b1;
			resp_r <= 1'b0;
		end else begin
			ready_r <= 1'b1;
			resp_r <= 1'b0;
		end
	end

	assign hrdata = rdata_r;
	assign hreadyout = ready_r;
	assign hresp = resp_r;
	assign irq = irq_r;

	// ****************************************
	// Assertions.
	// ****************************************
	property p_short;
		@(posedge hclk) disable iff (!hresetn)
		(rx_frame_done && rx_clean && rx_frame_len < mesc_pkg::MIN_FRAME_BYTES && !wr_pend_r)
		|=> cnt_if[0].value == $past(cnt_if[0].value) + 8'h01;
	endproperty
	a_short: assert property (p_short) else $error("short count missed"); // R1

	property p_short_dirty;
		@(posedge hclk) disable iff (!hresetn)
		(rx_crc_err && !wr_pend_r) |=> cnt_if[0].value == $past(cnt_if[0].value);
	endproperty
	a_short_dirty: assert property (p_short_dirty) else $error("bad frame counted"); // R1

	property p_hb;
		@(posedge hclk) disable iff (!hresetn)
		(hb_r == mesc_pkg::HB_TX && !tx_en) ##1 (!collision_indication)[*8]
		|-> hb_r == mesc_pkg::HB_WAIT;
	endproperty
	a_hb: assert property (p_hb) else $error("heartbeat wait ended early"); // R2

	property p_hb_fail;
		@(posedge hclk) disable iff (!hresetn)
		(hb_fail && !wr_pend_r) |=> cnt_if[1].value == $past(cnt_if[1].value) + 8'h01;
	endproperty
	a_hb_fail: assert property (p_hb_fail) else $error("heartbeat fail not counted"); // R2

	property p_lmis;
		@(posedge hclk) disable iff (!hresetn)
		(rx_frame_done && cfg_r[mesc_pkg::CFG_LEN_CHECK_BIT]
		&& rx_len_field < mesc_pkg::TYPE_ID_MIN && !rx_too_long
		&& rx_frame_len < rx_len_field && !wr_pend_r)
		|=> cnt_if[2].value == $past(cnt_if[2].value) + 8'h01;
	endproperty
	a_lmis: assert property (p_lmis) else $error("mismatch missed"); // R3

	property p_lmis_off;
		@(posedge hclk) disable iff (!hresetn)
		!cfg_r[mesc_pkg::CFG_LEN_CHECK_BIT] |-> !lmis_ev;
	endproperty
	a_lmis_off: assert property (p_lmis_off) else $error("check while disabled"); // R4

	property p_lmis_type;
		@(posedge hclk) disable iff (!hresetn)
		(rx_len_field >= mesc_pkg::TYPE_ID_MIN || rx_too_long) |-> !lmis_ev;
	endproperty
	a_lmis_type: assert property (p_lmis_type) else $error("type frame counted"); // R5

	property p_rd;
		@(posedge hclk) disable iff (!hresetn)
		(addr_ph && !hwrite && haddr == mesc_pkg::ADDR_SHORT) |=> hrdata[31:8] == 24'h0
		&& hrdata[7:0] == $past(cnt_if[0].value);
	endproperty
	a_rd: assert property (p_rd) else $error("counter read wrong"); // R6

	property p_wr;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_r && wr_addr_r == mesc_pkg::ADDR_HBEAT)
		|=> cnt_if[1].value == $past(hwdata[7:0]);
	endproperty
	a_wr: assert property (p_wr) else $error("counter write lost"); // R6

	c_short: cover property (@(posedge hclk) disable iff (!hresetn) ev[0]);
	c_hb: cover property (@(posedge hclk) disable iff (!hresetn) hb_fail);
	c_lmis: cover property (@(posedge hclk) disable iff (!hresetn) lmis_ev);
	c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule : mesc_stats

/* testbench/mesc_phy_model.sv */
`timescale 1ns/1ps
// ****
// Far-side frame status and transmit source.
// ****
module mesc_phy_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic rx_go,
	input wire logic [35:0] rx_req,
	input wire logic tx_go,
	input wire logic [7:0] col_at,
	output logic rx_frame_done,
	output logic [35:0] rx_bus,
	output logic tx_en,
	output logic collision_indication
);
	logic [7:0] n;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_frame_done <= 1'h0;
			rx_bus <= 36'h0;
			tx_en <= 1'h0;
			n <= 8'h0;
			collision_indication <= 1'h0;
		end else begin
			rx_frame_done <= rx_go;
			// Status lines mean nothing outside a frame end, so they toggle.
			rx_bus <= rx_go ? rx_req : ~rx_bus;
			collision_indication <= 1'h0;
			if (tx_go) begin
				tx_en <= 1'h1;
				n <= 8'h4;
			end else if (tx_en) begin
				tx_en <= (n != 8'h0);
				n <= (n == 8'h0) ? col_at : n - 8'h1;
			end else if (n != 8'h0) begin
				n <= n - 8'h1;
				collision_indication <= (n == 8'h1);
			end
		end
	end
endmodule : mesc_phy_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [15:0] len;
		logic [15:0] lf;
		logic [3:0] e;
		logic c;
		logic s;
		logic m;
	} mesc_row_t;
	logic hclk = 1'h0;
	logic hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_go, tx_go, done, tx_en, col, irq;
	logic [7:0] haddr, col_at, es, el;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	logic [35:0] rx_req, rx_bus;
	int errors, checked, cyc;
	mesc_row_t rows [11] = '{'{16'h3f, 16'h3f, 4'h0, 1'h0, 1'h1, 1'h0},
		'{16'h40, 16'h40, 4'h0, 1'h0, 1'h0, 1'h0}, '{16'h28, 16'h28, 4'h8, 1'h0, 1'h0, 1'h0},
		'{16'h28, 16'h28, 4'h4, 1'h0, 1'h0, 1'h0}, '{16'h28, 16'h28, 4'h2, 1'h0, 1'h0, 1'h0},
		'{16'h64, 16'hc8, 4'h0, 1'h1, 1'h0, 1'h1}, '{16'h64, 16'hc8, 4'h0, 1'h0, 1'h0, 1'h0},
		'{16'h64, 16'h600, 4'h0, 1'h1, 1'h0, 1'h0}, '{16'h64, 16'h5ff, 4'h0, 1'h1, 1'h0, 1'h1},
		'{16'h64, 16'hc8, 4'h1, 1'h1, 1'h0, 1'h0}, '{16'h28, 16'h32, 4'h0, 1'h1, 1'h1, 1'h1}};
	logic [7:0] hb_cfg [3] = '{8'h0, 8'h2, 8'h2};
	logic [7:0] hb_col [3] = '{8'h0, 8'h3, 8'h0};
	logic [31:0] hb_exp [3] = '{32'h0, 32'h0, 32'h1};
	always #2.5 hclk = ~hclk;
	assign hready = hreadyout;
	mesc_stats #(.HB_CYC(8)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_frame_done(done),
		.rx_frame_len(rx_bus[35:20]), .rx_len_field(rx_bus[19:4]), .rx_crc_err(rx_bus[3]),
		.rx_align_err(rx_bus[2]), .rx_symbol_err(rx_bus[1]), .rx_too_long(rx_bus[0]),
		.tx_en(tx_en), .collision_indication(col), .irq(irq));
	mesc_phy_model phy (.hclk(hclk), .hresetn(hresetn), .rx_go(rx_go), .rx_req(rx_req),
		.tx_go(tx_go), .col_at(col_at), .rx_frame_done(done), .rx_bus(rx_bus), .tx_en(tx_en),
		.collision_indication(col));
	task automatic hs(output logic [31:0] d);
		logic r;
		r = 1'h0;
		while (r !== 1'h1) begin
			@(posedge hclk);
			r = hready;
			d = hrdata;
		end
	endtask : hs
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hs(q);
		htrans <= 2'h0;
		hwdata <= d;
		hs(q);
	endtask : xfer
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'h0, a, 32'h0);
		chk(q, exp);
	endtask : rd
	task tally_and_finish;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, rx_go, rx_req, tx_go, col_at} = '0;
		{errors, checked, cyc, es, el} = '0;
		hsize = 3'h2;
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		for (int a = 0; a < 24; a += 4) rd(a[7:0], 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			xfer(1'h1, mesc_pkg::ADDR_CFG, {15'h0, rows[i].c, 16'h0});
			rx_go <= 1'h1;
			rx_req <= {rows[i].len, rows[i].lf, rows[i].e};
			@(posedge hclk);
			rx_go <= 1'h0;
			repeat (3) @(posedge hclk);
			es += rows[i].s;
			el += rows[i].m;
			rd(mesc_pkg::ADDR_SHORT, {24'h0, es});
			rd(mesc_pkg::ADDR_LMIS, {24'h0, el});
		end
		$display("frame rows test done");
		for (int i = 0; i < 3; i++) begin
			xfer(1'h1, mesc_pkg::ADDR_CFG, {24'h0, hb_cfg[i]});
			tx_go <= 1'h1;
			col_at <= hb_col[i];
			@(posedge hclk);
			tx_go <= 1'h0;
			repeat (20) @(posedge hclk);
			rd(mesc_pkg::ADDR_HBEAT, hb_exp[i]);
		end
		$display("heartbeat test done");
		xfer(1'h1, mesc_pkg::ADDR_SHORT, 32'hffff_ff5a);
		rd(mesc_pkg::ADDR_SHORT, 32'h5a);
		xfer(1'h1, mesc_pkg::ADDR_HBEAT, 32'hffff_ff33);
		rd(mesc_pkg::ADDR_HBEAT, 32'h33);
		xfer(1'h1, 8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
		$display("register test done");
		rd(mesc_pkg::ADDR_STAT, 32'h7);
		chk({31'h0, irq}, 32'h0);
		xfer(1'h1, mesc_pkg::ADDR_MASK, 32'h2);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		xfer(1'h1, mesc_pkg::ADDR_STAT, 32'h2);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rd(mesc_pkg::ADDR_STAT, 32'h5);
		$display("interrupt test done");
		// A short frame ends in the same cycle as a write-one clear of its status bit.
		rx_req <= {16'h0020, 16'h0020, 4'h0};
		rx_go <= 1'h1;
		fork
			xfer(1'h1, mesc_pkg::ADDR_STAT, 32'h1);
			begin
				@(posedge hclk);
				rx_go <= 1'h0;
			end
		join
		rd(mesc_pkg::ADDR_STAT, 32'h5);
		rd(mesc_pkg::ADDR_SHORT, 32'h5b);
		$display("set over clear test done");
		xfer(1'h1, mesc_pkg::ADDR_MASK, 32'h7);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd(mesc_pkg::ADDR_SHORT, 32'h0);
		rd(mesc_pkg::ADDR_MASK, 32'h0);
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule : tb_top
